// ==== hdl/rsc_sysreg_ctrl.sv ====
// four-world security system register fields and related controls
//
// Operation
// - non-walk granule fault reports code 101000 with both walk flags clear
// - stage 1 walk fault at level xx reports 1001xx, first-stage flag only
// - stage 2 walk fault alone reports 1001xx with second-stage flag only
// - stage 2 walk fault for stage 1 walk reports 1001xx, both flags
// - level minus one walk faults use code 100011, flags as usual
// - random id field reads 1 if feature, or trap feature and bit set
// - feature id bits 55:52 read 0 absent, 1 when extension present
// - feature id bits 31:28 read 1 when random trap supported, else 0
// - hypervisor bit 48 routes level 0/1 granule fault aborts to level 2
// - fault ipa bit 63 gives space; zero for nonsecure or realm level 2
// - limited ordering regs reachable when ns bit set; nonsecure PA only
// - debug comms bits 30:29 mirror external debug status bits
// - trace owner bits select owner; non-owners cannot trace when active
// - trace owner low bit 0 traps all level 1/2 accesses, else non-owners
// - owner extension bits read zero without extension; no root owner
// - profile owner bits select owner; profiling only in owning state
// - profile owner low bit 0 traps all level 1/2 accesses, else others
// - profiling always disabled at monitor level
// - syndrome carries stage 2 flag bit 21, stage 1 bit 7, code 5:0
`timescale 1ns/1ps
`include "rsc_defs.svh"

module rsc_sysreg_ctrl #(
    parameter bit HAS_SEC_EXT  = 1'b1,
    parameter bit HAS_RNG      = 1'b0,
    parameter bit HAS_RNG_TRAP = 1'b1
) (
    input  wire logic                        SYS_CLK,
    input  wire logic                        RST_N,
    input  rsc_pkg::rsc_sr_req_type          SR_IN,
    output logic                             SR_RVALID,
    output logic [`RSC_REG_W-1:0]            SR_RDATA,
    input  rsc_pkg::rsc_fault_type           FLT,
    input  wire logic                        FLT_FROM_LOW,
    input  wire logic                        FLT_IPA_NS,
    input  wire logic [`RSC_IPA_W-1:0]       FLT_IPA,
    input  rsc_pkg::rsc_state_type           CUR_STATE,
    input  wire logic [1:0]                  CUR_EL,
    input  wire logic [1:0]                  EXT_DBG_STATUS,
    input  wire logic                        TB_ACTIVE,
    input  wire logic                        TB_ACC,
    input  wire logic                        PB_ACC,
    input  wire logic                        LOR_PA_NS,
    output logic                             SYND_VALID,
    output logic [`RSC_SYND_W-1:0]           SYND,
    output logic                             ROUTE_TO_HYP,
    output logic                             TB_TRAP,
    output logic                             PB_TRAP,
    output logic                             TRACE_ALLOWED,
    output logic                             PROF_ENABLED,
    output logic                             LOR_ACCESS_OK,
    output logic                             LOR_APPLIES
);
    logic [`RSC_REG_W-1:0] hyp_config_q,  hyp_config_d;
    logic [`RSC_REG_W-1:0] fault_ipa_q,   fault_ipa_d;
    logic [`RSC_REG_W-1:0] mon_debug_q,   mon_debug_d;
    logic [`RSC_REG_W-1:0] mon_secure_q,  mon_secure_d;
    logic [`RSC_REG_W-1:0] rdata_d;
    logic [`RSC_REG_W-1:0] fault_ipa_hw;
    logic [`RSC_SYND_W-1:0] syndrome;
    logic                  tb_owner, tb_trap, pb_owner, pb_trap;

    wire  wr_hyp, wr_ipa, wr_mdcr, wr_scr;
    wire  random_trap_control;
    wire  address_space_select;
    wire  granule_fault_route;
    wire  taken_to_hyp;
    wire  [3:0] random_number_id_field;
    wire  [3:0] security_extension_field;
    wire  [3:0] random_trap_support_field;
    wire  [`RSC_REG_W-1:0] mdcr_mask;
    wire  [`RSC_REG_W-1:0] hcr_mask;
    wire  rd_any, rd_feat0, rd_feat1, rd_isa0, rd_hyp;
    wire  rd_ipa, rd_dbg, rd_mdcr, rd_scr;
    wire  route_d, trace_allowed_d, prof_enabled_d;
    wire  [`RSC_SYND_W-1:0] synd_d;

    function automatic logic sel_write(input rsc_pkg::rsc_sr_req_type r,
                                       input rsc_pkg::rsc_sel_type s);
        sel_write = r.req && r.wr && (r.sel == s);
    endfunction

    function automatic logic sel_read(input rsc_pkg::rsc_sr_req_type r,
                                      input rsc_pkg::rsc_sel_type s);
        sel_read = r.req && !r.wr && (r.sel == s);
    endfunction

    assign wr_hyp  = sel_write(SR_IN, rsc_pkg::SEL_HYP_CONFIG);
    assign wr_ipa  = sel_write(SR_IN, rsc_pkg::SEL_HYP_FAULT_IPA);
    assign wr_mdcr = sel_write(SR_IN, rsc_pkg::SEL_MONITOR_DEBUG_CONFIG);
    assign wr_scr  = sel_write(SR_IN, rsc_pkg::SEL_MONITOR_SECURE_CONFIG);

    assign random_trap_control  = mon_secure_q[`RSC_SCR_RTRAP_BIT];
    assign address_space_select = mon_secure_q[`RSC_SCR_NS_BIT];
    assign granule_fault_route  = hyp_config_q[`RSC_HCR_ROUTE_BIT];

    // identification fields are pure decode of build options and state
    assign random_number_id_field =
        (HAS_RNG || (HAS_RNG_TRAP && random_trap_control))
            ? `RSC_ID_PRESENT : `RSC_ID_ABSENT;
    assign security_extension_field =
        HAS_SEC_EXT ? `RSC_ID_PRESENT : `RSC_ID_ABSENT;
    assign random_trap_support_field =
        HAS_RNG_TRAP ? `RSC_ID_PRESENT : `RSC_ID_ABSENT;

    // fields that do not exist without the extension are held at zero
    assign hcr_mask  = HAS_SEC_EXT ? '1
                     : ~(64'h1 << `RSC_HCR_ROUTE_BIT);
    assign mdcr_mask = HAS_SEC_EXT ? '1
                     : ~((64'h1 << `RSC_MDCR_TB_EXT_BIT)
                       | (64'h1 << `RSC_MDCR_PB_EXT_BIT));

    // granule faults from the lower levels go to hypervisor level on route
    assign taken_to_hyp = FLT.valid
        && ((FLT_FROM_LOW && granule_fault_route)
            || (CUR_EL == 2'h2));

    always_comb begin
        fault_ipa_hw = '0;
        fault_ipa_hw[`RSC_HPFAR_IPA_LSB +: `RSC_IPA_W] = FLT_IPA;
        // only a secure hypervisor has two ipa spaces to tell apart
        fault_ipa_hw[`RSC_HPFAR_NS_BIT] =
            (CUR_STATE == rsc_pkg::SEC_SECURE) && FLT_IPA_NS;
    end

    // hardware capture wins over a software write in the same cycle
    assign fault_ipa_d = taken_to_hyp ? fault_ipa_hw
                       : wr_ipa       ? SR_IN.wdata : fault_ipa_q;
    assign hyp_config_d = wr_hyp  ? (SR_IN.wdata & hcr_mask)
                                  : hyp_config_q;
    assign mon_debug_d  = wr_mdcr ? (SR_IN.wdata & mdcr_mask)
                                  : mon_debug_q;
    // the trap control is meant to be set once by monitor software
    assign mon_secure_d = wr_scr  ? SR_IN.wdata : mon_secure_q;

    rsc_syndrome_enc u_synd (
        .fault    (FLT),
        .syndrome (syndrome)
    );

    rsc_owner_dec u_trace_owner (
        .ext_present (HAS_SEC_EXT),
        .ext_bit     (mon_debug_q[`RSC_MDCR_TB_EXT_BIT]),
        .owner_field (mon_debug_q[`RSC_MDCR_TB_OWN_LSB +: 2]),
        .cur_state   (CUR_STATE),
        .cur_el      (CUR_EL),
        .access      (TB_ACC),
        .owner_match (tb_owner),
        .trap        (tb_trap)
    );

    rsc_owner_dec u_prof_owner (
        .ext_present (HAS_SEC_EXT),
        .ext_bit     (mon_debug_q[`RSC_MDCR_PB_EXT_BIT]),
        .owner_field (mon_debug_q[`RSC_MDCR_PB_OWN_LSB +: 2]),
        .cur_state   (CUR_STATE),
        .cur_el      (CUR_EL),
        .access      (PB_ACC),
        .owner_match (pb_owner),
        .trap        (pb_trap)
    );

    // each select is decoded once for the mux; the strobe uses rd_any, any read
    assign rd_any   = SR_IN.req && !SR_IN.wr;
    assign rd_feat0 = sel_read(SR_IN, rsc_pkg::SEL_FEATURE_ID_ZERO);
    assign rd_feat1 = sel_read(SR_IN, rsc_pkg::SEL_FEATURE_ID_ONE);
    assign rd_isa0  = sel_read(SR_IN, rsc_pkg::SEL_ISA_ID_ZERO);
    assign rd_hyp   = sel_read(SR_IN, rsc_pkg::SEL_HYP_CONFIG);
    assign rd_ipa   = sel_read(SR_IN, rsc_pkg::SEL_HYP_FAULT_IPA);
    assign rd_dbg   = sel_read(SR_IN, rsc_pkg::SEL_DEBUG_COMMS_STATUS);
    assign rd_mdcr  = sel_read(SR_IN, rsc_pkg::SEL_MONITOR_DEBUG_CONFIG);
    assign rd_scr   = sel_read(SR_IN, rsc_pkg::SEL_MONITOR_SECURE_CONFIG);

    // writes and idle cycles read as zero, so the bus stays quiet
    always_comb begin
        rdata_d = '0;
        if (rd_feat0) begin
            rdata_d[`RSC_PFR0_SEC_LSB +: 4] = security_extension_field;
        end else if (rd_feat1) begin
            rdata_d[`RSC_PFR1_RTRAP_LSB +: 4] = random_trap_support_field;
        end else if (rd_isa0) begin
            rdata_d[`RSC_ISAR0_RNG_LSB +: 4] = random_number_id_field;
        end else if (rd_hyp) begin
            rdata_d = hyp_config_q;
        end else if (rd_ipa) begin
            rdata_d = fault_ipa_q;
        end else if (rd_dbg) begin
            rdata_d[`RSC_MDCCSR_LSB +: 2] = EXT_DBG_STATUS;
        end else if (rd_mdcr) begin
            rdata_d = mon_debug_q;
        end else if (rd_scr) begin
            rdata_d = mon_secure_q;
        end
    end

    // output decodes, registered below so every pin leaves a flip-flop
    assign synd_d          = FLT.valid ? syndrome : '0;
    assign route_d         = FLT.valid && FLT_FROM_LOW
                          && granule_fault_route;
    // monitor level never traces, whatever the owner says
    assign trace_allowed_d = (CUR_EL != 2'h3)
                          && (!TB_ACTIVE || tb_owner);
    // no owner code names root, so profiling is off at monitor level
    assign prof_enabled_d  = pb_owner && (CUR_EL != 2'h3);

    // unknown architectural resets are pinned to zero for determinism
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            hyp_config_q <= `RSC_REG_RESET;
        end else begin
            hyp_config_q <= hyp_config_d;
        end
    end

    // a fault taken to hypervisor level and a write in one cycle keep the fault, the write is lost
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            fault_ipa_q <= `RSC_REG_RESET;
        end else begin
            fault_ipa_q <= fault_ipa_d;
        end
    end

    // reserved owner codes are not filtered; software must avoid them
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            mon_debug_q <= `RSC_REG_RESET;
        end else begin
            mon_debug_q <= mon_debug_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            mon_secure_q <= `RSC_REG_RESET;
        end else begin
            mon_secure_q <= mon_secure_d;
        end
    end

    // a read answers exactly one cycle after its request, for one cycle
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            SR_RVALID <= 1'b0;
            SR_RDATA  <= '0;
        end else begin
            SR_RVALID <= rd_any;
            SR_RDATA  <= rdata_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            SYND_VALID <= 1'b0;
            SYND       <= '0;
        end else begin
            SYND_VALID <= FLT.valid;
            SYND       <= synd_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ROUTE_TO_HYP <= 1'b0;
        end else begin
            ROUTE_TO_HYP <= route_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            TB_TRAP <= 1'b0;
            PB_TRAP <= 1'b0;
        end else begin
            TB_TRAP <= tb_trap;
            PB_TRAP <= pb_trap;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            TRACE_ALLOWED <= 1'b0;
            PROF_ENABLED  <= 1'b0;
        end else begin
            TRACE_ALLOWED <= trace_allowed_d;
            PROF_ENABLED  <= prof_enabled_d;
        end
    end

    // regions only ever cover the nonsecure physical space
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            LOR_ACCESS_OK <= 1'b0;
            LOR_APPLIES   <= 1'b0;
        end else begin
            LOR_ACCESS_OK <= address_space_select;
            LOR_APPLIES   <= LOR_PA_NS;
        end
    end
endmodule // rsc_sysreg_ctrl

// ==== hdl/rsc_defs.svh ====
// field positions, encodings and reset values for the security sysreg block
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_SR_SEL_W          3
`define RSC_REG_W             64
`define RSC_REG_RESET         64'h0000000000000000
`define RSC_IPA_W             40
`define RSC_SYND_W            25

`define RSC_FSC_NO_WALK       6'h28
`define RSC_FSC_WALK_BASE     4'h9
`define RSC_FSC_WALK_LVL_M1   6'h23
`define RSC_SYND_S2_BIT       21
`define RSC_SYND_S1_BIT       7
`define RSC_SYND_FSC_MSB      5

`define RSC_ID_ABSENT         4'h0
`define RSC_ID_PRESENT        4'h1
`define RSC_PFR0_SEC_LSB      52
`define RSC_PFR1_RTRAP_LSB    28
`define RSC_ISAR0_RNG_LSB     60

`define RSC_HCR_ROUTE_BIT     48
`define RSC_HPFAR_NS_BIT      63
`define RSC_HPFAR_IPA_LSB     4
`define RSC_MDCCSR_LSB        29
`define RSC_MDCR_TB_EXT_BIT   26
`define RSC_MDCR_TB_OWN_LSB   24
`define RSC_MDCR_PB_EXT_BIT   11
`define RSC_MDCR_PB_OWN_LSB   12
`define RSC_SCR_RTRAP_BIT     40
`define RSC_SCR_NS_BIT        0

`endif

// ==== hdl/rsc_pkg.sv ====
// types shared by the security sysreg block
package rsc_pkg;

    // coded as {extension, address space select}
    typedef enum logic [1:0] {
        SEC_SECURE,
        SEC_NONSECURE,
        SEC_ROOT,
        SEC_REALM
    } rsc_state_type;

    typedef enum logic [2:0] {
        SEL_FEATURE_ID_ZERO,
        SEL_FEATURE_ID_ONE,
        SEL_ISA_ID_ZERO,
        SEL_HYP_CONFIG,
        SEL_HYP_FAULT_IPA,
        SEL_DEBUG_COMMS_STATUS,
        SEL_MONITOR_DEBUG_CONFIG,
        SEL_MONITOR_SECURE_CONFIG
    } rsc_sel_type;

    typedef struct packed {
        logic        valid;
        logic        first_stage_walk_flag;
        logic        second_stage_walk_flag;
        logic        level_minus_one;
        logic [1:0]  level;
    } rsc_fault_type;

    typedef struct packed {
        logic        req;
        logic        wr;
        rsc_sel_type sel;
        logic [63:0] wdata;
    } rsc_sr_req_type;

endpackage

// ==== hdl/rsc_syndrome_enc.sv ====
// granule protection check syndrome encoder
`timescale 1ns/1ps
`include "rsc_defs.svh"

module rsc_syndrome_enc (
    input  rsc_pkg::rsc_fault_type  fault,
    output logic [`RSC_SYND_W-1:0]  syndrome
);
    wire       on_walk;
    wire [5:0] fault_status_code;

    assign on_walk = fault.first_stage_walk_flag
                   | fault.second_stage_walk_flag;
    // level -1 only exists for walks; a non-walk ignores the level inputs
    assign fault_status_code =
        !on_walk              ? `RSC_FSC_NO_WALK :
        fault.level_minus_one ? `RSC_FSC_WALK_LVL_M1 :
                                {`RSC_FSC_WALK_BASE, fault.level};

    always_comb begin
        syndrome = '0;
        syndrome[`RSC_SYND_S2_BIT] = fault.second_stage_walk_flag;
        syndrome[`RSC_SYND_S1_BIT] = fault.first_stage_walk_flag;
        syndrome[`RSC_SYND_FSC_MSB:0] = fault_status_code;
    end
endmodule // rsc_syndrome_enc

// ==== hdl/rsc_owner_dec.sv ====
// owner decode and lower-level trap for a trace or profiling buffer
`timescale 1ns/1ps

module rsc_owner_dec (
    input  logic                  ext_present,
    input  logic                  ext_bit,
    input  logic [1:0]            owner_field,
    input  rsc_pkg::rsc_state_type cur_state,
    input  logic [1:0]            cur_el,
    input  logic                  access,
    output logic                  owner_match,
    output logic                  trap
);
    wire       ext_eff;
    wire       reserved_code;
    wire       is_owner;
    wire       low_level;
    rsc_pkg::rsc_state_type owner;

    // extension bit reads as zero when the extension is absent
    assign ext_eff = ext_present & ext_bit;
    // reserved codes own nothing, so every state is non-owning
    assign reserved_code = ext_eff & ~owner_field[1];
    assign owner = ext_eff        ? rsc_pkg::SEC_REALM :
                   owner_field[1] ? rsc_pkg::SEC_NONSECURE :
                                    rsc_pkg::SEC_SECURE;
    // root never owns: monitor level is excluded
    assign is_owner = !reserved_code && (cur_state == owner)
                    && (cur_el != 2'h3);
    assign owner_match = is_owner;
    assign low_level = (cur_el == 2'h1) || (cur_el == 2'h2);
    // low bit clear traps everything, set traps non-owners only
    assign trap = access && low_level
                && (!owner_field[0] || !is_owner);
endmodule // rsc_owner_dec

// ==== test/rsc_sysreg_monitor.sv ====
// assertion checker for the security sysreg block
`timescale 1ns/1ps
module rsc_sysreg_monitor (
    input  wire logic               SYS_CLK,
    input  wire logic               RST_N,
    input  rsc_pkg::rsc_sr_req_type SR_IN,
    input  wire logic               SR_RVALID,
    input  wire logic [63:0]        SR_RDATA,
    input  rsc_pkg::rsc_fault_type  FLT,
    input  wire logic               FLT_FROM_LOW,
    input  wire logic [1:0]         CUR_EL,
    input  wire logic [1:0]         EXT_DBG_STATUS,
    input  wire logic               LOR_PA_NS,
    input  wire logic               SYND_VALID,
    input  wire logic [24:0]        SYND,
    input  wire logic               ROUTE_TO_HYP,
    input  wire logic               TB_TRAP,
    input  wire logic               PB_TRAP,
    input  wire logic               TRACE_ALLOWED,
    input  wire logic               PROF_ENABLED,
    input  wire logic               LOR_APPLIES
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    wire walk = FLT.first_stage_walk_flag || FLT.second_stage_walk_flag;

    chk_synd_pulse: assert property (FLT.valid |=> SYND_VALID)
        else $error("syndrome pulse missing");
    chk_no_walk: assert property (
        FLT.valid && !walk |=> SYND == 25'h28)
        else $error("non-walk syndrome wrong");
    chk_walk_code: assert property (
        FLT.valid && walk && !FLT.level_minus_one
        |=> SYND[5:0] == {4'h9, $past(FLT.level)})
        else $error("walk status code wrong");
    chk_minus_one: assert property (
        FLT.valid && walk && FLT.level_minus_one |=> SYND[5:0] == 6'h23)
        else $error("level minus one code wrong");
    chk_walk_flags: assert property (FLT.valid |=>
        SYND[21] == $past(FLT.second_stage_walk_flag) &&
        SYND[7] == $past(FLT.first_stage_walk_flag))
        else $error("walk flags wrong");
    chk_route_cause: assert property (
        ROUTE_TO_HYP |-> $past(FLT.valid) && $past(FLT_FROM_LOW))
        else $error("route without low fault");
    chk_trap_levels: assert property (
        CUR_EL == 2'h0 || CUR_EL == 2'h3 |=> !TB_TRAP && !PB_TRAP)
        else $error("trap outside levels 1 and 2");
    chk_monitor_quiet: assert property (
        CUR_EL == 2'h3 |=> !PROF_ENABLED && !TRACE_ALLOWED)
        else $error("trace or profiling at monitor level");
    chk_dbg_mirror: assert property (
        SR_IN.req && !SR_IN.wr && SR_IN.sel == rsc_pkg::SEL_DEBUG_COMMS_STATUS
        |=> SR_RVALID && SR_RDATA[30:29] == $past(EXT_DBG_STATUS))
        else $error("debug status mirror wrong");
    chk_lor_delay: assert property (
        1'b1 |=> LOR_APPLIES == $past(LOR_PA_NS))
        else $error("region space flag wrong");

    cover property (FLT.valid && walk && FLT.level_minus_one);
    cover property (ROUTE_TO_HYP);
    cover property (TB_TRAP && PB_TRAP);
endmodule // rsc_sysreg_monitor

bind rsc_sysreg_ctrl rsc_sysreg_monitor u_rsc_sysreg_monitor (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SR_IN(SR_IN),
    .SR_RVALID(SR_RVALID), .SR_RDATA(SR_RDATA), .FLT(FLT),
    .FLT_FROM_LOW(FLT_FROM_LOW), .CUR_EL(CUR_EL),
    .EXT_DBG_STATUS(EXT_DBG_STATUS), .LOR_PA_NS(LOR_PA_NS),
    .SYND_VALID(SYND_VALID), .SYND(SYND), .ROUTE_TO_HYP(ROUTE_TO_HYP),
    .TB_TRAP(TB_TRAP), .PB_TRAP(PB_TRAP), .TRACE_ALLOWED(TRACE_ALLOWED),
    .PROF_ENABLED(PROF_ENABLED), .LOR_APPLIES(LOR_APPLIES));

// ==== test/testbench.sv ====
// self-checking testbench for the security sysreg block
`timescale 1ns/1ps
module testbench;
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    rsc_pkg::rsc_sr_req_type sr_in = '0;
    rsc_pkg::rsc_fault_type  flt = '0;
    rsc_pkg::rsc_state_type  cur_state = rsc_pkg::SEC_SECURE;
    logic [1:0]              cur_el = 2'h0;
    logic [1:0]              ext_dbg = 2'h0;
    logic                    low = 1'b0, ipa_ns = 1'b0, pa_ns = 1'b0;
    logic                    tb_act = 1'b0, tb_acc = 1'b0, pb_acc = 1'b0;
    logic [39:0]             ipa = '0;
    logic                    rvalid, s_valid, route, tb_trap, pb_trap;
    logic                    trace_ok, prof_en, lor_ok, lor_app;
    logic [63:0]             rdata;
    logic [24:0]             synd;
    logic [63:0]             exp_ipa = '0;
    logic                    hcr_route = 1'b0;
    int                      mismatches = 0;
    int                      checked = 0;
    int                      seed = 18006;

    always #25 sys_clk = ~sys_clk;

    rsc_sysreg_ctrl u_rsc_sysreg_ctrl (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .SR_IN(sr_in),
        .SR_RVALID(rvalid), .SR_RDATA(rdata), .FLT(flt),
        .FLT_FROM_LOW(low), .FLT_IPA_NS(ipa_ns), .FLT_IPA(ipa),
        .CUR_STATE(cur_state), .CUR_EL(cur_el), .EXT_DBG_STATUS(ext_dbg),
        .TB_ACTIVE(tb_act), .TB_ACC(tb_acc), .PB_ACC(pb_acc),
        .LOR_PA_NS(pa_ns), .SYND_VALID(s_valid), .SYND(synd),
        .ROUTE_TO_HYP(route), .TB_TRAP(tb_trap), .PB_TRAP(pb_trap),
        .TRACE_ALLOWED(trace_ok), .PROF_ENABLED(prof_en),
        .LOR_ACCESS_OK(lor_ok), .LOR_APPLIES(lor_app));

    task automatic compare(string what, logic [63:0] e, logic [63:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // one idle cycle between accesses keeps req from being set twice
    task automatic sr_access(logic wr, logic [2:0] sel, logic [63:0] d);
        @(posedge sys_clk);
        sr_in <= '{1'b1, wr, rsc_pkg::rsc_sel_type'(sel), d};
        @(posedge sys_clk);
        sr_in.req <= 1'b0;
        #1;
        compare("read valid", 64'(!wr), 64'(rvalid));
    endtask

    function automatic logic [24:0] exp_synd(logic [4:0] k);
        logic [5:0] c;
        c = !(k[0] || k[1]) ? 6'h28 : k[2] ? 6'h23 : {4'h9, k[4:3]};
        return {3'h0, k[1], 13'h0, k[0], 1'b0, c};
    endfunction

    function automatic logic own(logic e, logic [1:0] f);
        if (cur_el == 2'h3) return 1'b0;
        if (e) return f[1] && cur_state == rsc_pkg::SEC_REALM;
        return cur_state == (f[1] ? rsc_pkg::SEC_NONSECURE
                                  : rsc_pkg::SEC_SECURE);
    endfunction

    function automatic logic tr(logic e, logic [1:0] f, logic a);
        return a && (cur_el == 2'h1 || cur_el == 2'h2)
            && (!f[0] || !own(e, f));
    endfunction

    task automatic fault(logic [4:0] k);
        @(posedge sys_clk);
        flt <= '{1'b1, k[0], k[1], k[2], k[4:3]};
        low <= 1'($random(seed));
        ipa_ns <= 1'($random(seed));
        ipa <= 40'({$random(seed), $random(seed)});
        cur_el <= 2'($random(seed));
        cur_state <= rsc_pkg::rsc_state_type'(2'($random(seed)));
        @(posedge sys_clk);
        flt.valid <= 1'b0;
        #1;
        if ((low && hcr_route) || cur_el == 2'h2) begin
            exp_ipa = {ipa_ns && cur_state == rsc_pkg::SEC_SECURE,
                       19'h0, ipa, 4'h0};
        end
        compare("synd valid", 64'h1, 64'(s_valid));
        compare("syndrome", 64'(exp_synd(k)), 64'(synd));
        compare("route", 64'(low && hcr_route), 64'(route));
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end

    initial begin
        logic [1:0]  tf, pf;
        logic        te, pe;
        logic [63:0] mv;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset values chosen as zero
        for (int i = 3; i < 8; i++) begin
            if (i != 5) begin
                sr_access(1'b0, 3'(i), '0);
                compare("reset value", 64'h0, rdata);
            end
        end
        // writes to id registers are ignored
        sr_access(1'b1, 3'h0, '1);
        sr_access(1'b0, 3'h0, '0);
        compare("ext id", 64'h1 << 52, rdata & 64'hF << 52);
        sr_access(1'b0, 3'h1, '0);
        compare("trap id", 64'h1 << 28, rdata & 64'hF << 28);
        $display("test id fields done");
        for (int k = 0; k < 2; k++) begin
            sr_access(1'b1, 3'h7, 64'(k) << 40 | 64'(k));
            sr_access(1'b0, 3'h2, '0);
            compare("rng id", 64'(k) << 60, rdata & 64'hF << 60);
            compare("lor access", 64'(k), 64'(lor_ok));
        end
        repeat (4) begin
            @(posedge sys_clk);
            ext_dbg <= 2'($random(seed));
            pa_ns <= 1'($random(seed));
            sr_access(1'b0, 3'h5, '0);
            compare("dbg status", {33'h0, ext_dbg, 29'h0}, rdata);
            compare("lor applies", 64'(pa_ns), 64'(lor_app));
        end
        $display("test monitor config done");
        for (int h = 0; h < 2; h++) begin
            if (h == 1) begin
                sr_access(1'b1, 3'h3, 64'h1 << 48);
                hcr_route = 1'b1;
                sr_access(1'b0, 3'h3, '0);
                compare("hyp config", 64'h1 << 48, rdata);
            end
            for (int k = 0; k < 32; k++) begin
                fault(5'(k));
            end
        end
        sr_access(1'b0, 3'h4, '0);
        compare("fault ipa", exp_ipa, rdata & 64'h80000FFFFFFFFFF0);
        $display("test faults done");
        repeat (80) begin
            {te, tf, pe, pf} = 6'($random(seed));
            if (te) tf[1] = 1'b1;
            if (pe) pf[1] = 1'b1;
            mv = 64'(te) << 26 | 64'(tf) << 24 | 64'(pe) << 11 | 64'(pf) << 12;
            sr_access(1'b1, 3'h6, mv);
            @(posedge sys_clk);
            cur_state <= rsc_pkg::rsc_state_type'(2'($random(seed)));
            cur_el <= 2'($random(seed));
            {tb_act, tb_acc, pb_acc} <= 3'($random(seed));
            @(posedge sys_clk);
            #1;
            compare("tb trap", 64'(tr(te, tf, tb_acc)), 64'(tb_trap));
            compare("pb trap", 64'(tr(pe, pf, pb_acc)), 64'(pb_trap));
            compare("trace", 64'(cur_el != 2'h3 && (!tb_act || own(te, tf))),
                    64'(trace_ok));
            compare("prof", 64'(own(pe, pf)), 64'(prof_en));
        end
        sr_access(1'b0, 3'h6, '0);
        compare("debug config", mv, rdata);
        $display("test owners done");
        test_done();
    end
endmodule // testbench
